// file: design/flash_host_pkg.sv
// Purpose: Shared constants for the parallel flash command host.
// Assumes: x16 flash on an asynchronous bus, driven from a 125 MHz clock.
// Notes: Command codes, status bit positions and strobe timing live here.
package flash_host_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_PROT_SETUP = 8'hC0;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_DOWN = 8'h2F;
  localparam logic [7:0] CMD_UNLOCK = 8'hD0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam int MACHINE_READY_BIT = 7;
  localparam int PROGRAM_SUSPENDED_BIT = 2;
  localparam int CLK_PERIOD_NS = 8;
  localparam int STROBE_NS = 70;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_NS = 30;
  localparam int RECOVER_CYC =
    (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // Host operation codes on op_i.
  typedef enum logic [2:0] {
    OP_WRITE_CMD,
    OP_READ,
    OP_WRITE_PAIR,
    OP_POLL_STATUS,
    OP_SUSPEND,
    OP_RESUME
  } host_op_t;
endpackage

// file: design/bus_cycle.sv
// Purpose: One asynchronous flash bus cycle (read or write) with timing.
// Assumes: Flash data pins are a tri-state set split into in, out and enable.
// Notes: A cycle always deasserts both strobes at its end, so consecutive
// status reads toggle the chip enable.
`timescale 1ns/1ns
module bus_cycle
#(
  parameter int HOLD_CYC = flash_host_pkg::STROBE_CYC,
  parameter int GAP_CYC = flash_host_pkg::RECOVER_CYC
)
(
  input wire logic clk_sys_i, // System clock.
  input wire logic rst_n_i, // Synchronised active-low reset.
  input wire logic start_i, // Pulse: begin a cycle.
  input wire logic write_i, // High for a write cycle.
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i, // Cycle address.
  input wire logic [flash_host_pkg::DATA_W-1:0] wdata_i, // Write data.
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i, // Flash data pins in.
  output logic [flash_host_pkg::ADDR_W-1:0] a_o, // Flash address pins.
  output logic [flash_host_pkg::DATA_W-1:0] dq_o, // Flash data pins out.
  output logic dq_oe_o, // High while driving data pins.
  output logic ce_n_o, // Chip enable, active low.
  output logic oe_n_o, // Output enable, active low.
  output logic we_n_o, // Write enable, active low.
  output logic [flash_host_pkg::DATA_W-1:0] rdata_o, // Data from a read.
  output logic done_o // Pulse: cycle finished.
);
  import flash_host_pkg::*;

  typedef enum {CY_IDLE, CY_STROBE, CY_GAP} cyc_state_t;
  cyc_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic wr_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= CY_IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state_reg)
        CY_IDLE:
          if (start_i)
          begin
            state_reg <= CY_STROBE;
            wr_reg <= write_i;
            cnt_reg <= CNT_W'(HOLD_CYC - 1);
          end
        CY_STROBE:
          if (cnt_reg == '0)
          begin
            state_reg <= CY_GAP;
            cnt_reg <= CNT_W'(GAP_CYC - 1);
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        CY_GAP:
          if (cnt_reg == '0)
          begin
            state_reg <= CY_IDLE;
            done_o <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        default:
          state_reg <= CY_IDLE;
      endcase
    end
  end

  // Pin drive: strobes low only in CY_STROBE; data sampled at its last edge.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      a_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      rdata_o <= '0;
    end
    else
    begin
      if (state_reg == CY_IDLE && start_i)
      begin
        a_o <= addr_i;
        dq_o <= wdata_i;
        dq_oe_o <= write_i;
        ce_n_o <= 1'b0;
        oe_n_o <= write_i;
        we_n_o <= !write_i;
      end
      else if (state_reg == CY_STROBE && cnt_reg == '0)
      begin
        ce_n_o <= 1'b1;
        oe_n_o <= 1'b1;
        we_n_o <= 1'b1;
        if (!wr_reg)
          rdata_o <= dq_i;
      end
      else if (state_reg == CY_GAP && cnt_reg == '0)
        dq_oe_o <= 1'b0;
    end
  end

  // Counts the cycles that chip enable has stood low, for the check below.
  logic [CNT_W-1:0] low_cnt_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      low_cnt_reg <= '0;
    else if (ce_n_o)
      low_cnt_reg <= '0;
    else
      low_cnt_reg <= low_cnt_reg + 1'b1;
  end

  property p_strobe_width;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(ce_n_o) |-> low_cnt_reg == CNT_W'(HOLD_CYC);
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("Strobe width wrong.");
endmodule

// file: design/flash_cmd_host.sv
// Purpose: Host controller that drives a flash command interface by pins.
// Assumes: Requests wait for busy_o low; flash pins sampled synchronously.
// Notes: Issues command sequences and polls the status register.
// Notes on behaviour
// - Host writes 0xB0 to suspend programming.
// - Host writes 0x70 then reads status.
// - Toggle strobe between polls to refresh status.
// - Host writes 0xFF to read array.
// - Suspended reads avoid the programming block.
// - Host resumes with 0xD0 at any address.
// - Lock confirm 01 lock, D0 unlock, 2F down.
`timescale 1ns/1ns
module flash_cmd_host
(
  input wire logic clk_sys_i, // System clock, 125 MHz.
  input wire logic rst_n_i, // Asynchronous active-low reset.
  input wire logic req_i, // Pulse: start an operation.
  input wire flash_host_pkg::host_op_t op_i, // Operation select.
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i, // Target address.
  input wire logic [flash_host_pkg::DATA_W-1:0] data_i, // First word or code.
  input wire logic [flash_host_pkg::DATA_W-1:0] data2_i, // Second word.
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i, // Flash data pins in.
  output logic [flash_host_pkg::ADDR_W-1:0] a_o, // Flash address pins.
  output logic [flash_host_pkg::DATA_W-1:0] dq_o, // Flash data pins out.
  output logic dq_oe_o, // Data pin drive enable.
  output logic ce_n_o, // Flash chip enable, low active.
  output logic oe_n_o, // Flash output enable, low active.
  output logic we_n_o, // Flash write enable, low active.
  output logic busy_o, // High while an operation runs.
  output logic done_o, // Pulse: operation finished.
  output logic [flash_host_pkg::DATA_W-1:0] rdata_o, // Read or status data.
  output logic suspended_o, // Program was suspended (level).
  output logic in_suspend_o // Host believes program is suspended.
);
  import flash_host_pkg::*;

  typedef enum {
    H_IDLE, H_CYC1, H_CYC2, H_POLL_CMD, H_POLL_RD, H_READ_ARRAY
  } host_state_t;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  host_state_t state_reg;
  host_op_t op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] d1_reg;
  logic [DATA_W-1:0] d2_reg;
  logic cyc_start_reg;
  logic cyc_write_reg;
  logic [DATA_W-1:0] cyc_wdata_reg;
  logic [DATA_W-1:0] cyc_rdata;
  logic cyc_done;

  function automatic logic [DATA_W-1:0] cmd_word(input logic [7:0] c);
    cmd_word = {{(DATA_W-8){1'b0}}, c};
  endfunction

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  bus_cycle bus_cycle_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n), .start_i(cyc_start_reg),
    .write_i(cyc_write_reg), .addr_i(addr_reg), .wdata_i(cyc_wdata_reg),
    .dq_i(dq_i), .a_o(a_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
    .rdata_o(cyc_rdata), .done_o(cyc_done)
  );

  // Sequencer: each state issues one bus cycle and waits for it to end.
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= H_IDLE;
      op_reg <= OP_WRITE_CMD;
      addr_reg <= '0;
      d1_reg <= '0;
      d2_reg <= '0;
      cyc_start_reg <= 1'b0;
      cyc_write_reg <= 1'b0;
      cyc_wdata_reg <= '0;
    end
    else
    begin
      cyc_start_reg <= 1'b0;
      case (state_reg)
        H_IDLE:
          if (req_i)
          begin
            op_reg <= op_i;
            addr_reg <= addr_i;
            d1_reg <= data_i;
            d2_reg <= data2_i;
            cyc_start_reg <= 1'b1;
            state_reg <= H_CYC1;
            case (op_i)
              OP_READ:
                cyc_write_reg <= 1'b0;
              OP_SUSPEND:
              begin
                cyc_write_reg <= 1'b1;
                cyc_wdata_reg <= cmd_word(CMD_SUSPEND);
              end
              OP_RESUME:
              begin
                cyc_write_reg <= 1'b1;
                cyc_wdata_reg <= cmd_word(CMD_RESUME);
              end
              OP_POLL_STATUS:
              begin
                cyc_write_reg <= 1'b1;
                cyc_wdata_reg <= cmd_word(CMD_READ_STATUS);
                state_reg <= H_POLL_CMD;
              end
              default:
              begin
                // Setup code first; lock, erase and program pairs.
                cyc_write_reg <= 1'b1;
                cyc_wdata_reg <= data_i;
              end
            endcase
          end
        H_CYC1:
          if (cyc_done)
          begin
            if (op_reg == OP_WRITE_PAIR)
            begin
              // Second word is data or confirm, taken as is.
              cyc_wdata_reg <= d2_reg;
              cyc_write_reg <= 1'b1;
              cyc_start_reg <= 1'b1;
              state_reg <= H_CYC2;
            end
            else if (op_reg == OP_SUSPEND)
            begin
              cyc_wdata_reg <= cmd_word(CMD_READ_STATUS);
              cyc_write_reg <= 1'b1;
              cyc_start_reg <= 1'b1;
              state_reg <= H_POLL_CMD;
            end
            else
              state_reg <= H_IDLE;
          end
        H_CYC2:
          if (cyc_done)
            state_reg <= H_IDLE;
        H_POLL_CMD:
          if (cyc_done)
          begin
            cyc_write_reg <= 1'b0;
            cyc_start_reg <= 1'b1;
            state_reg <= H_POLL_RD;
          end
        H_POLL_RD:
          if (cyc_done)
          begin
            // Each new read cycle toggles the strobes again.
            if (!cyc_rdata[MACHINE_READY_BIT])
            begin
              cyc_write_reg <= 1'b0;
              cyc_start_reg <= 1'b1;
            end
            else if (op_reg == OP_SUSPEND)
            begin
              // Suspended or completed, read array follows.
              cyc_wdata_reg <= cmd_word(CMD_READ_ARRAY);
              cyc_write_reg <= 1'b1;
              cyc_start_reg <= 1'b1;
              state_reg <= H_READ_ARRAY;
            end
            else
              state_reg <= H_IDLE;
          end
        H_READ_ARRAY:
          if (cyc_done)
            state_reg <= H_IDLE;
        default:
          state_reg <= H_IDLE;
      endcase
    end
  end

  // Result reporting for the user side.
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= '0;
      suspended_o <= 1'b0;
      in_suspend_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (state_reg == H_IDLE && req_i)
        busy_o <= 1'b1;
      if (cyc_done && (state_reg == H_CYC1 || state_reg == H_CYC2) &&
          !(state_reg == H_CYC1 &&
            (op_reg == OP_WRITE_PAIR || op_reg == OP_SUSPEND)))
      begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
        if (op_reg == OP_READ)
          rdata_o <= cyc_rdata;
        if (op_reg == OP_RESUME)
          in_suspend_o <= 1'b0;
      end
      if (state_reg == H_POLL_RD && cyc_done &&
          cyc_rdata[MACHINE_READY_BIT])
      begin
        rdata_o <= cyc_rdata;
        if (op_reg == OP_SUSPEND)
        begin
          suspended_o <= cyc_rdata[PROGRAM_SUSPENDED_BIT];
          in_suspend_o <= cyc_rdata[PROGRAM_SUSPENDED_BIT];
        end
        else
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
      if (state_reg == H_READ_ARRAY && cyc_done)
      begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end

  property p_poll_until_ready;
    @(posedge clk_sys_i) disable iff (!rst_n)
      (state_reg == H_POLL_RD && cyc_done && !cyc_rdata[MACHINE_READY_BIT])
        |=> cyc_start_reg && state_reg == H_POLL_RD;
  endproperty
  a_poll_until_ready: assert property (p_poll_until_ready)
    else $error("Busy status did not trigger another poll.");
  property p_suspend_code;
    @(posedge clk_sys_i) disable iff (!rst_n)
      (state_reg == H_IDLE && req_i && op_i == OP_SUSPEND)
        |=> cyc_wdata_reg == cmd_word(CMD_SUSPEND) && cyc_start_reg;
  endproperty
  a_suspend_code: assert property (p_suspend_code)
    else $error("Suspend code not issued.");
  property p_resume_code;
    @(posedge clk_sys_i) disable iff (!rst_n)
      (state_reg == H_IDLE && req_i && op_i == OP_RESUME)
        |=> cyc_wdata_reg == cmd_word(CMD_RESUME);
  endproperty
  a_resume_code: assert property (p_resume_code)
    else $error("Resume code not issued.");
  property p_status_cmd;
    @(posedge clk_sys_i) disable iff (!rst_n)
      $rose(state_reg == H_POLL_CMD)
        |-> cyc_wdata_reg == cmd_word(CMD_READ_STATUS) && cyc_write_reg;
  endproperty
  a_status_cmd: assert property (p_status_cmd)
    else $error("Status poll without read-status command.");
  property p_suspended_flag;
    @(posedge clk_sys_i) disable iff (!rst_n)
      (state_reg == H_POLL_RD && cyc_done && cyc_rdata[MACHINE_READY_BIT]
        && op_reg == OP_SUSPEND)
        |=> suspended_o == $past(cyc_rdata[PROGRAM_SUSPENDED_BIT]);
  endproperty
  a_suspended_flag: assert property (p_suspended_flag)
    else $error("Suspended flag does not match status.");
  property p_array_after_suspend;
    @(posedge clk_sys_i) disable iff (!rst_n)
      $rose(state_reg == H_READ_ARRAY)
        |-> cyc_wdata_reg == cmd_word(CMD_READ_ARRAY);
  endproperty
  a_array_after_suspend: assert property (p_array_after_suspend)
    else $error("Read array code missing after suspend.");
  property p_pair_second;
    @(posedge clk_sys_i) disable iff (!rst_n)
      $rose(state_reg == H_CYC2) |-> cyc_wdata_reg == d2_reg;
  endproperty
  a_pair_second: assert property (p_pair_second)
    else $error("Second word of pair wrong.");
endmodule

// file: verif/flash_dev_model.sv
// Purpose: Behavioural flash command state machine facing the host.
// Assumes: Commands are taken on the rising edge of the write strobe.
// Notes: Busy time is a plain delay; status refreshes on a strobe fall.
`timescale 1ns/1ns
module flash_dev_model
#(
  parameter int BUSY_NS = 3000,
  parameter int SUSP_NS = 100,
  parameter logic [15:0] CFG_WORD = 16'h1234, // Arbitrary value.
  parameter logic [15:0] QRY_WORD = 16'h0051
)
(
  input wire logic ce_n_i, // Chip enable.
  input wire logic oe_n_i, // Output enable.
  input wire logic we_n_i, // Write enable.
  input wire logic [21:0] a_i, // Address.
  input wire logic [15:0] d_i, // Data from the host.
  output logic [15:0] d_o, // Data to the host.
  output logic [7:0] lock_o // Last lock confirm code.
);
  typedef enum logic [4:0] {ARR, STS, CFG, QRY, LKS, LKE, LKD, PPS, PP,
    PGS, PG, SST, SAR, SCF, SQR, ES, EE, ER} st_t;
  st_t st = ARR;
  time busy_end = 0;
  time left = 0;
  logic susp = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [15:0] rd;
  logic [7:0] sr = 8'h80;
  logic [7:0] c;
  logic [6:0] pblk = 7'h00;
  logic wsel = 1'b0;

  function automatic logic ready();
    return $time >= busy_end;
  endfunction

  initial lock_o = 8'h00;

  // Both strobes rise in one instant at the end of a write, so chip enable
  // is judged just after the write strobe falls.
  always @(negedge we_n_i)
    #1 wsel = !ce_n_i;

  always @(posedge we_n_i)
  begin
    c = d_i[7:0];
    if (st inside {PP, PG, ER} && ready())
      st = STS;
    if (wsel)
      case (st)
        LKS:
        begin
          st = (c inside {8'h01, 8'h2F, 8'hD0}) ? LKD : LKE;
          lock_o = (st == LKD) ? c : lock_o;
        end
        PPS, PGS:
        begin
          st = (st == PPS) ? PP : PG;
          busy_end = $time + BUSY_NS;
          pblk = a_i[21:15];
        end
        PP, ER: ;
        PG:
          if (c == 8'hB0)
          begin
            left = busy_end - $time;
            susp = 1'b1;
            st = SST;
            busy_end = $time + SUSP_NS;
          end
        ES:
          if (c == 8'hD0)
          begin
            st = ER;
            busy_end = $time + BUSY_NS;
          end
          else
            st = EE;
        SST, SAR, SCF, SQR:
          case (c)
            8'h90: st = SCF;
            8'h98: st = SQR;
            8'h70: st = SST;
            8'hD0:
            begin
              st = PG;
              susp = 1'b0;
              busy_end = $time + left;
            end
            default: st = SAR;
          endcase
        default:
          case (c)
            8'h90: st = CFG;
            8'h98: st = QRY;
            8'h60: st = LKS;
            8'hC0: st = PPS;
            8'h70: st = STS;
            8'h40, 8'h10: st = PGS;
            8'h20: st = ES;
            default: st = ARR;
          endcase
      endcase
  end

  // Status is frozen between strobe toggles, as the real part does.
  always @(negedge ce_n_i or negedge oe_n_i)
    sr = {ready(), 4'h0, susp & ready(), 2'h0};

  always @*
    case (st)
      ARR, SAR:
        rd = (st == SAR && a_i[21:15] == pblk) ? ~(a_i[15:0] ^ 16'hA5C3)
          : (a_i[15:0] ^ 16'hA5C3);
      CFG, SCF: rd = CFG_WORD;
      QRY, SQR: rd = QRY_WORD;
      default: rd = {8'h00, sr};
    endcase

  // A released bus shows the inverse of the last word, never a copy.
  always @(posedge oe_n_i)
    last = rd;
  assign d_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
endmodule

// file: verif/tb_flash_cmd_host.sv
// Purpose: Self-checking bench for the flash command host.
// Assumes: Behavioural flash model on the far side of the pins.
// Notes: Random idle commands plus lock, suspend and erase corners.
`timescale 1ns/1ns
module tb_flash_cmd_host;
  import flash_host_pkg::*;
  `define CHK(g, e) \
    begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end end
  localparam logic [15:0] CFG = 16'h1234; // Arbitrary value.
  localparam logic [15:0] QRY = 16'h0051;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  host_op_t op = OP_READ;
  logic [ADDR_W-1:0] addr = '0;
  logic [ADDR_W-1:0] a_o;
  logic [DATA_W-1:0] d1 = '0;
  logic [DATA_W-1:0] d2 = '0;
  logic [DATA_W-1:0] dq_o, dev_d, rdata, dq_w;
  logic dq_oe, ce_n, oe_n, we_n, busy, done, susp, in_susp;
  logic [7:0] lock;
  int n_fail = 0;
  int comparisons = 0;

  assign dq_w = dq_oe ? dq_o : dev_d;

  flash_cmd_host flash_cmd_host_inst (.clk_sys_i(clk), .rst_n_i(rst_n),
    .req_i(req), .op_i(op), .addr_i(addr), .data_i(d1), .data2_i(d2),
    .dq_i(dq_w), .a_o(a_o), .dq_o(dq_o), .dq_oe_o(dq_oe), .ce_n_o(ce_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .busy_o(busy), .done_o(done),
    .rdata_o(rdata), .suspended_o(susp), .in_suspend_o(in_susp));

  flash_dev_model #(.CFG_WORD(CFG), .QRY_WORD(QRY)) flash_dev_model_inst (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .a_i(a_o), .d_i(dq_w),
    .d_o(dev_d), .lock_o(lock));

  initial
    forever #4 clk = ~clk;

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic run(host_op_t o, logic [21:0] a, logic [15:0] x1,
    logic [15:0] x2);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    op = o;
    addr = a;
    d1 = x1;
    d2 = x2;
    req = 1'b1;
    @(posedge clk);
    #1;
    req = 1'b0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'b1)
      n_fail++;
  endtask

  function automatic logic [15:0] exp_rd(logic [7:0] c, logic [21:0] a);
    case (c)
      8'h90: return CFG;
      8'h98: return QRY;
      8'h70: return 16'h0080;
      default: return a[15:0] ^ 16'hA5C3;
    endcase
  endfunction

  initial
  begin
    #400000;
    n_fail++;
    finish_test();
  end

  initial
  begin
    logic [21:0] a;
    logic [21:0] b;
    logic [7:0] c;
    logic [7:0] idle [4] = '{8'h90, 8'h98, 8'hFF, 8'h70};
    logic [7:0] lk [3] = '{8'h01, 8'hD0, 8'h2F};
    logic [7:0] sc [6] = '{8'h90, 8'h98, 8'h60, 8'hC0, 8'h01, 8'h2F};
    void'($urandom(20));
    repeat (2) @(posedge clk);
    `CHK({ce_n, oe_n, we_n, dq_oe, busy}, 5'b11100)
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++)
    begin
      c = idle[$urandom_range(3)];
      a = 22'($urandom);
      run(OP_WRITE_CMD, a, {8'h00, c}, '0);
      run(OP_READ, a, '0, '0);
      `CHK(rdata, exp_rd(c, a))
    end
    for (int i = 0; i < 3; i++)
    begin
      a = 22'($urandom);
      run(OP_WRITE_CMD, a, {8'h00, lk[i]}, '0);
      run(OP_READ, a, '0, '0);
      `CHK(rdata, exp_rd(8'hFF, a))
      run(OP_WRITE_PAIR, a, 16'h0060, {8'h00, lk[i]});
      `CHK(lock, lk[i])
      run(OP_READ, a, '0, '0);
      `CHK(rdata, 16'h0080)
    end
    run(OP_WRITE_PAIR, a, 16'h0060, 16'h0098);
    run(OP_READ, a, '0, '0);
    `CHK(rdata, 16'h0080)
    run(OP_WRITE_PAIR, a, 16'h00C0, 16'($urandom));
    run(OP_WRITE_CMD, a, 16'h0090, '0);
    run(OP_READ, a, '0, '0);
    `CHK(rdata, 16'h0000)
    run(OP_POLL_STATUS, a, '0, '0);
    `CHK(rdata, 16'h0080)
    run(OP_WRITE_CMD, a, 16'h0090, '0);
    run(OP_READ, a, '0, '0);
    `CHK(rdata, CFG)
    a = 22'($urandom);
    b = a ^ 22'h200000;
    run(OP_WRITE_PAIR, a, 16'h0040, 16'($urandom));
    run(OP_SUSPEND, a, '0, '0);
    `CHK({susp, in_susp}, 2'b11)
    `CHK(rdata, 16'h0084)
    run(OP_READ, b, '0, '0);
    `CHK(rdata, exp_rd(8'hFF, b))
    for (int i = 0; i < 6; i++)
    begin
      run(OP_WRITE_CMD, b, {8'h00, sc[i]}, '0);
      run(OP_READ, b, '0, '0);
      `CHK(rdata, exp_rd(sc[i], b))
    end
    run(OP_RESUME, a, '0, '0);
    `CHK(in_susp, 1'b0)
    run(OP_POLL_STATUS, a, '0, '0);
    `CHK(rdata, 16'h0080)
    run(OP_WRITE_PAIR, a, 16'h0040, 16'($urandom));
    repeat (500) @(posedge clk);
    run(OP_SUSPEND, a, '0, '0);
    `CHK({susp, in_susp}, 2'b00)
    run(OP_READ, a, '0, '0);
    `CHK(rdata, exp_rd(8'hFF, a))
    run(OP_WRITE_PAIR, a, 16'h0020, 16'h00FF);
    run(OP_READ, a, '0, '0);
    `CHK(rdata, 16'h0080)
    run(OP_WRITE_PAIR, a, 16'h0020, 16'h00D0);
    run(OP_WRITE_CMD, a, 16'h0098, '0);
    run(OP_READ, a, '0, '0);
    `CHK(rdata, 16'h0000)
    run(OP_POLL_STATUS, a, '0, '0);
    `CHK(rdata, 16'h0080)
    finish_test();
  end
endmodule
